// ===== seven_lane_consts.svh
`ifndef SEVEN_LANE_CONSTS_SVH
`define SEVEN_LANE_CONSTS_SVH

// ==========================================================
// Word and lane shape
`define SD_WORD_BITS      28
`define SD_LANES          4
`define SD_SLOTS          7
`define SD_SLOT_W         3
`define SD_LAST_SLOT      3'h6
`define SD_CLK_HIGH_SLOTS 3'h4

// ==========================================================
// Slot pacing and lock
`define SD_PERIOD_W       12
`define SD_SLOT_STEP      7
`define SD_EDGES_FOR_LOCK 2'h2
`define SD_FIFO_DEPTH     16

// ==========================================================
// Timing
`define SD_CLK_PERIOD_NS  25
`define SD_SETTLE_TIME_MS 10
`define SD_SETTLE_CYCLES  ((`SD_SETTLE_TIME_MS * 1000000 + `SD_CLK_PERIOD_NS - 1) / `SD_CLK_PERIOD_NS)

`endif

// ===== seven_lane_pkg.sv
package seven_lane_pkg;

    typedef enum logic [1:0] {
        TX_OFF,
        TX_SETTLE,
        TX_RUN
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_OFF,
        RX_SETTLE,
        RX_TRAIN,
        RX_FILL,
        RX_RUN
    } rx_state_e;

endpackage

// ===== slot_timing_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

interface slot_timing_if;
    logic                  rise;
    logic [`SD_SLOT_W-1:0] slot;
    logic                  period_valid;

    modport timer (
        output rise,
        output slot,
        output period_valid
    );

    modport user (
        input rise,
        input slot,
        input period_valid
    );
endinterface

`default_nettype wire

// ===== stream_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

// DEPTH must be a power of two
module stream_fifo #(
    parameter int WIDTH = `SD_WORD_BITS,
    parameter int DEPTH = `SD_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready    = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
        out_valid   = wr_ptr != rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
        push        = in_valid & in_ready;
        pop         = out_valid & out_ready;
        next_wr_ptr = flush ? '0 : wr_ptr + (AW+1)'(push);
        next_rd_ptr = flush ? '0 : rd_ptr + (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

`default_nettype wire

// ===== slot_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

// Measures the word period and paces seven slots across it
module slot_timer #(
    parameter int PERIOD_W = `SD_PERIOD_W
) (
    input  wire logic    clk,
    input  wire logic    srst,
    input  wire logic    run,
    input  wire logic    clk_level,
    slot_timing_if.timer tim
);
    logic                  prev;
    logic [PERIOD_W-1:0]   phase;
    logic [PERIOD_W-1:0]   period;
    logic [PERIOD_W-1:0]   acc;
    logic [`SD_SLOT_W-1:0] slot;
    logic [1:0]            edges;
    logic [PERIOD_W-1:0]   next_phase;
    logic [PERIOD_W-1:0]   next_period;
    logic [PERIOD_W-1:0]   next_acc;
    logic [`SD_SLOT_W-1:0] next_slot;
    logic [1:0]            next_edges;
    logic [PERIOD_W:0]     stepped;
    logic                  rise;
    logic                  timeout;

    always_comb begin
        rise    = clk_level & ~prev;
        // Link clock lost: no edge within twice the last period
        timeout = (phase == '1) ||
                  ((edges == `SD_EDGES_FOR_LOCK) && ({1'b0, phase} > {period, 1'b0}));
        stepped = {1'b0, acc} + (PERIOD_W+1)'(`SD_SLOT_STEP);
        next_phase  = (phase == '1) ? phase : phase + 1'b1;
        next_period = period;
        next_acc    = acc;
        next_slot   = slot;
        next_edges  = edges;
        if (!run) begin
            next_phase = '0;
            next_acc   = '0;
            next_slot  = '0;
            next_edges = '0;
        end else if (rise) begin
            next_phase  = '0;
            next_acc    = '0;
            next_slot   = '0;
            next_period = phase + 1'b1;
            next_edges  = (edges == `SD_EDGES_FOR_LOCK) ? edges : edges + 1'b1;
        end else if (timeout) begin
            next_edges = '0;
        end else if (stepped >= {1'b0, period}) begin
            // Seven steps of one seventh period each; slot saturates at the last
            next_acc  = PERIOD_W'(stepped - {1'b0, period});
            next_slot = (slot == `SD_LAST_SLOT) ? slot : slot + 1'b1;
        end else begin
            next_acc = stepped[PERIOD_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev   <= 1'b0;
            phase  <= '0;
            period <= '0;
            acc    <= '0;
            slot   <= '0;
            edges  <= '0;
        end else begin
            prev   <= clk_level;
            phase  <= next_phase;
            period <= next_period;
            acc    <= next_acc;
            slot   <= next_slot;
            edges  <= next_edges;
        end
    end

    assign tim.rise         = rise & run;
    assign tim.slot         = slot;
    assign tim.period_valid = (edges == `SD_EDGES_FOR_LOCK) && !timeout;
endmodule

`default_nettype wire

// ===== seven_to_one_lane_serdes.sv
// What this block does
// - Transmitter spreads all 28 input bits over lanes
// - Seven bit slots per lane each word period
// - Four differential data lanes, true and complement
// - Word clock forwarded on its own lane
// - Input word captured on word clock rising edge
// - Transmitter power-down floats all serial outputs
// - Receiver rebuilds 28-bit word from four lanes
// - Forwarded clock locates the receiver bit slots
// - Output clock rising edge qualifies output word
// - Receiver power-down holds parallel outputs
// - Each slot lasts one seventh of period
// - No toggling until settle time after power-up
// - Power-down accepted at any cycle
// - Lost forwarded clock stops output clock, holds data
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

module seven_to_one_lane_serdes #(
    parameter int SETTLE_CYCLES = `SD_SETTLE_CYCLES,
    parameter int FIFO_DEPTH    = `SD_FIFO_DEPTH
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     tx_word_clock_in,
    input  wire logic [`SD_WORD_BITS-1:0] tx_parallel_in,
    input  wire logic                     tx_power_down_n,
    output logic      [`SD_LANES-1:0]     tx_serial_lane_p,
    output logic      [`SD_LANES-1:0]     tx_serial_lane_n,
    output logic                          tx_serial_lane_oe,
    output logic                          tx_forwarded_clock_p,
    output logic                          tx_forwarded_clock_n,
    output logic                          tx_forwarded_clock_oe,
    output logic                          tx_overrun,
    input  wire logic [`SD_LANES-1:0]     rx_serial_lane_p,
    input  wire logic [`SD_LANES-1:0]     rx_serial_lane_n,
    input  wire logic                     rx_forwarded_clock_p,
    input  wire logic                     rx_forwarded_clock_n,
    input  wire logic                     rx_power_down_n,
    output logic      [`SD_WORD_BITS-1:0] rx_parallel_out,
    output logic                          rx_word_clock_out,
    output logic                          rx_locked
);
    localparam int WB        = `SD_WORD_BITS;
    localparam int LN        = `SD_LANES;
    localparam int SLOTS     = `SD_SLOTS;
    localparam int TX_SYNC_W = WB + 2;
    localparam int RX_SYNC_W = 2 * LN + 3;
    localparam int SETTLE_W  = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

    // ==========================================================
    // Pin synchronisers
    logic [TX_SYNC_W-1:0]     tx_meta;
    logic [TX_SYNC_W-1:0]     tx_sync;
    logic [RX_SYNC_W-1:0]     rx_meta;
    logic [RX_SYNC_W-1:0]     rx_sync;
    logic                     tx_pwr;
    logic                     tx_clk_level;
    logic [WB-1:0]            tx_data;
    logic                     rx_pwr;
    logic                     rx_clk_level;
    logic [LN-1:0]            rx_bits;
    logic [LN-1:0]            rx_lane_d;

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_meta   <= '0;
            tx_sync   <= '0;
            rx_meta   <= '0;
            rx_sync   <= '0;
            rx_lane_d <= '0;
        end else begin
            tx_meta   <= {tx_power_down_n, tx_word_clock_in, tx_parallel_in};
            tx_sync   <= tx_meta;
            rx_meta   <= {rx_power_down_n, rx_forwarded_clock_p, rx_forwarded_clock_n,
                          rx_serial_lane_p, rx_serial_lane_n};
            rx_sync   <= rx_meta;
            // Matches the edge detector's extra stage on the clock lane
            rx_lane_d <= rx_bits;
        end
    end

    always_comb begin
        tx_pwr       = tx_sync[WB+1];
        tx_clk_level = tx_sync[WB];
        tx_data      = tx_sync[WB-1:0];
        rx_pwr       = rx_sync[2*LN+2];
        rx_clk_level = rx_sync[2*LN+1] & ~rx_sync[2*LN];
        rx_bits      = rx_sync[2*LN-1:LN] & ~rx_sync[LN-1:0];
    end

    // ==========================================================
    // Slot timing for both ends
    slot_timing_if tx_tim ();
    slot_timing_if rx_tim ();

    slot_timer u_tx_timer (
        .clk       (clk),
        .srst      (srst),
        .run       (tx_pwr),
        .clk_level (tx_clk_level),
        .tim       (tx_tim.timer)
    );

    slot_timer u_rx_timer (
        .clk       (clk),
        .srst      (srst),
        .run       (rx_pwr),
        .clk_level (rx_clk_level),
        .tim       (rx_tim.timer)
    );

    // ==========================================================
    // Transmit word buffer
    logic                     tx_push;
    logic                     tx_pop;
    logic                     tx_fifo_ready;
    logic                     tx_head_valid;
    logic [WB-1:0]            tx_head;

    stream_fifo #(
        .WIDTH (WB),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .srst      (srst),
        .flush     (~tx_pwr),
        .in_valid  (tx_push),
        .in_ready  (tx_fifo_ready),
        .in_data   (tx_data),
        .out_valid (tx_head_valid),
        .out_ready (tx_pop),
        .out_data  (tx_head)
    );

    // ==========================================================
    // Transmitter
    seven_lane_pkg::tx_state_e tx_state;
    seven_lane_pkg::tx_state_e next_tx_state;
    logic [SETTLE_W-1:0]      tx_settle;
    logic [SETTLE_W-1:0]      next_tx_settle;
    logic [WB-1:0]            tx_word;
    logic [WB-1:0]            next_tx_word;
    logic                     next_tx_overrun;
    logic [LN-1:0]            tx_lane_bit;
    logic [LN-1:0]            next_lane_p;
    logic [LN-1:0]            next_lane_n;
    logic                     next_fclk;
    logic                     next_tx_oe;

    // Lane l slot k carries word bit l*7+k, slot 0 first
    for (genvar l = 0; l < LN; l++) begin : g_tx_lane
        assign tx_lane_bit[l] = tx_word[l * SLOTS + int'(tx_tim.slot)];
    end

    always_comb begin
        next_tx_state   = tx_state;
        next_tx_settle  = tx_settle;
        next_tx_word    = tx_word;
        next_tx_overrun = tx_overrun;
        tx_push         = 1'b0;
        tx_pop          = 1'b0;
        case (tx_state)
            seven_lane_pkg::TX_OFF: begin
                next_tx_state  = seven_lane_pkg::TX_SETTLE;
                next_tx_settle = '0;
            end
            seven_lane_pkg::TX_SETTLE: begin
                if (tx_settle != SETTLE_LAST) begin
                    next_tx_settle = tx_settle + 1'b1;
                end else if (tx_tim.period_valid && tx_tim.rise) begin
                    next_tx_state = seven_lane_pkg::TX_RUN;
                end
            end
            seven_lane_pkg::TX_RUN: begin
                if (!tx_tim.period_valid) begin
                    next_tx_state = seven_lane_pkg::TX_SETTLE;
                end
            end
            default: begin
                next_tx_state = seven_lane_pkg::TX_OFF;
            end
        endcase
        // Power-down wins in any cycle, mid-word or not
        if (!tx_pwr) begin
            next_tx_state   = seven_lane_pkg::TX_OFF;
            next_tx_overrun = 1'b0;
            next_tx_word    = '0;
        end
        if ((next_tx_state == seven_lane_pkg::TX_RUN) && tx_tim.rise) begin
            tx_push      = 1'b1;
            tx_pop       = tx_head_valid;
            // Empty buffer sends an all-zero word rather than repeating one
            next_tx_word = tx_head_valid ? tx_head : '0;
        end
        if (tx_push && !tx_fifo_ready) begin
            next_tx_overrun = 1'b1;
        end
    end

    always_comb begin
        next_tx_oe  = tx_pwr && (tx_state != seven_lane_pkg::TX_OFF);
        next_lane_p = '0;
        next_lane_n = '1;
        next_fclk   = 1'b0;
        if (tx_state == seven_lane_pkg::TX_RUN) begin
            next_lane_p = tx_lane_bit;
            next_lane_n = ~tx_lane_bit;
            next_fclk   = tx_tim.slot < `SD_CLK_HIGH_SLOTS;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state              <= seven_lane_pkg::TX_OFF;
            tx_settle             <= '0;
            tx_word               <= '0;
            tx_overrun            <= 1'b0;
            tx_serial_lane_p      <= '0;
            tx_serial_lane_n      <= '0;
            tx_serial_lane_oe     <= 1'b0;
            tx_forwarded_clock_p  <= 1'b0;
            tx_forwarded_clock_n  <= 1'b0;
            tx_forwarded_clock_oe <= 1'b0;
        end else begin
            tx_state              <= next_tx_state;
            tx_settle             <= next_tx_settle;
            tx_word               <= next_tx_word;
            tx_overrun            <= next_tx_overrun;
            tx_serial_lane_p      <= next_lane_p;
            tx_serial_lane_n      <= next_lane_n;
            tx_serial_lane_oe     <= next_tx_oe;
            tx_forwarded_clock_p  <= next_fclk;
            tx_forwarded_clock_n  <= ~next_fclk;
            tx_forwarded_clock_oe <= next_tx_oe;
        end
    end

    // ==========================================================
    // Receiver
    seven_lane_pkg::rx_state_e rx_state;
    seven_lane_pkg::rx_state_e next_rx_state;
    logic [SETTLE_W-1:0]      rx_settle;
    logic [SETTLE_W-1:0]      next_rx_settle;
    logic [WB-1:0]            rx_asm;
    logic [WB-1:0]            rx_asm_in;
    logic [WB-1:0]            next_rx_asm;
    logic [WB-1:0]            next_rx_out;
    logic                     next_rx_clk;
    logic                     rx_filling;

    // Same map as the transmitter, inverted
    for (genvar b = 0; b < WB; b++) begin : g_rx_bit
        assign rx_asm_in[b] = (rx_tim.slot == `SD_SLOT_W'(b % SLOTS)) ?
                              rx_lane_d[b / SLOTS] : rx_asm[b];
    end

    always_comb begin
        next_rx_state  = rx_state;
        next_rx_settle = rx_settle;
        next_rx_out    = rx_parallel_out;
        next_rx_clk    = rx_word_clock_out;
        case (rx_state)
            seven_lane_pkg::RX_OFF: begin
                next_rx_state  = seven_lane_pkg::RX_SETTLE;
                next_rx_settle = '0;
            end
            seven_lane_pkg::RX_SETTLE: begin
                if (rx_settle != SETTLE_LAST) begin
                    next_rx_settle = rx_settle + 1'b1;
                end else begin
                    next_rx_state = seven_lane_pkg::RX_TRAIN;
                end
            end
            seven_lane_pkg::RX_TRAIN: begin
                if (rx_tim.period_valid && rx_tim.rise) begin
                    next_rx_state = seven_lane_pkg::RX_FILL;
                end
            end
            seven_lane_pkg::RX_FILL: begin
                if (!rx_tim.period_valid) begin
                    next_rx_state = seven_lane_pkg::RX_TRAIN;
                end else if (rx_tim.rise) begin
                    next_rx_state = seven_lane_pkg::RX_RUN;
                end
            end
            seven_lane_pkg::RX_RUN: begin
                if (!rx_tim.period_valid) begin
                    next_rx_state = seven_lane_pkg::RX_TRAIN;
                end
            end
            default: begin
                next_rx_state = seven_lane_pkg::RX_OFF;
            end
        endcase
        if (!rx_pwr) begin
            next_rx_state = seven_lane_pkg::RX_OFF;
        end
        rx_filling  = (rx_state == seven_lane_pkg::RX_FILL) ||
                      (rx_state == seven_lane_pkg::RX_RUN);
        next_rx_asm = rx_filling ? rx_asm_in : rx_asm;
        // Outside RUN the word and clock simply hold their last level
        if ((next_rx_state == seven_lane_pkg::RX_RUN) && rx_tim.rise) begin
            next_rx_out = rx_asm_in;
            next_rx_clk = 1'b0;
        end else if ((next_rx_state == seven_lane_pkg::RX_RUN) &&
                     (rx_tim.slot >= `SD_CLK_HIGH_SLOTS)) begin
            // Rises mid-word so the data is set up well before it
            next_rx_clk = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state          <= seven_lane_pkg::RX_OFF;
            rx_settle         <= '0;
            rx_asm            <= '0;
            rx_parallel_out   <= '0;
            rx_word_clock_out <= 1'b0;
            rx_locked         <= 1'b0;
        end else begin
            rx_state          <= next_rx_state;
            rx_settle         <= next_rx_settle;
            rx_asm            <= next_rx_asm;
            rx_parallel_out   <= next_rx_out;
            rx_word_clock_out <= next_rx_clk;
            rx_locked         <= next_rx_state == seven_lane_pkg::RX_RUN;
        end
    end
endmodule

`default_nettype wire

// ===== serdes_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

// ==========================================================
// Port checker
module serdes_link_monitor (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire logic                     tx_power_down_n,
    input wire logic [`SD_LANES-1:0]     tx_serial_lane_p,
    input wire logic [`SD_LANES-1:0]     tx_serial_lane_n,
    input wire logic                     tx_serial_lane_oe,
    input wire logic                     tx_forwarded_clock_p,
    input wire logic                     tx_forwarded_clock_n,
    input wire logic                     tx_forwarded_clock_oe,
    input wire logic                     rx_power_down_n,
    input wire logic [`SD_WORD_BITS-1:0] rx_parallel_out,
    input wire logic                     rx_word_clock_out,
    input wire logic                     rx_locked
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    lane_pair_a: assert property (tx_serial_lane_oe |-> tx_serial_lane_n == ~tx_serial_lane_p)
        else $error("lane pair not complementary");
    clock_pair_a: assert property (tx_forwarded_clock_oe |-> tx_forwarded_clock_n != tx_forwarded_clock_p)
        else $error("clock pair not complementary");
    enables_agree_a: assert property (tx_forwarded_clock_oe == tx_serial_lane_oe)
        else $error("clock and lane enables differ");
    tx_float_a: assert property (!tx_power_down_n [*5] |-> !tx_serial_lane_oe)
        else $error("lanes driven during power-down");
    settle_quiet_a: assert property (!tx_serial_lane_oe && $rose(tx_power_down_n) |=>
        ($stable(tx_serial_lane_p) && $stable(tx_forwarded_clock_p)) [*8])
        else $error("lanes toggled before settling");
    rx_hold_a: assert property (!rx_power_down_n [*4] |=> $stable(rx_parallel_out))
        else $error("output word moved during power-down");
    rx_pd_unlock_a: assert property (!rx_power_down_n [*5] |-> !rx_locked)
        else $error("receiver locked during power-down");
    out_clock_lock_a: assert property ($rose(rx_word_clock_out) |-> rx_locked)
        else $error("output clock edge without lock");
    word_at_low_a: assert property ($changed(rx_parallel_out) |-> !rx_word_clock_out)
        else $error("output word changed while clock high");

    cover property ($rose(rx_locked));
    cover property ($fell(tx_serial_lane_oe));
    cover property ($rose(rx_word_clock_out) ##8 $rose(rx_word_clock_out));
endmodule

bind seven_to_one_lane_serdes serdes_link_monitor serdes_link_monitor_inst (.clk, .srst,
    .tx_power_down_n, .tx_serial_lane_p, .tx_serial_lane_n, .tx_serial_lane_oe,
    .tx_forwarded_clock_p, .tx_forwarded_clock_n, .tx_forwarded_clock_oe,
    .rx_power_down_n, .rx_parallel_out, .rx_word_clock_out, .rx_locked);

`default_nettype wire

// ===== link_cable.sv
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

// ==========================================================
// Far end: cable into a matching receiver front end
module link_cable (
    input wire logic                 clk,
    input wire logic [`SD_LANES-1:0] lane_p,
    input wire logic [`SD_LANES-1:0] lane_n,
    input wire logic                 lane_oe,
    input wire logic                 fclk_p,
    input wire logic                 fclk_n,
    input wire logic                 fclk_oe,
    output logic     [`SD_LANES-1:0] rx_lane_p = 4'h0,
    output logic     [`SD_LANES-1:0] rx_lane_n = 4'h0,
    output logic                     rx_fclk_p = 1'b0,
    output logic                     rx_fclk_n = 1'b0
);
    logic [9:0] last = 10'h000;

    // Undriven pairs have no pull: show the inverse of the last level, then stand still
    always @(posedge clk) begin
        if (lane_oe && fclk_oe) begin
            last <= {lane_p, lane_n, fclk_p, fclk_n};
            {rx_lane_p, rx_lane_n, rx_fclk_p, rx_fclk_n} <= {lane_p, lane_n, fclk_p, fclk_n};
        end else begin
            {rx_lane_p, rx_lane_n, rx_fclk_p, rx_fclk_n} <= ~last;
        end
    end
endmodule

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "seven_lane_consts.svh"

module tb_top;
    localparam int SETTLE = 20;
    logic        clk = 1'b0, srst = 1'b1, wclk = 1'b0, tx_pd_n = 1'b0, rx_pd_n = 1'b0;
    logic [27:0] tx_word = 28'h000_0000, rx_word;
    logic [3:0]  lp, ln, rlp, rln;
    logic        lane_oe, fp, fn, f_oe, rfp, rfn, rx_clk, locked, ovr, rx_prev = 1'b0;
    logic        chk_on = 1'b0, seen = 1'b0;
    logic [7:0]  n = 8'h00, last_v = 8'h00;
    int          fail_count = 0, num_checks = 0, got = 0, cyc = 0;

    function automatic logic [27:0] pat(input logic [7:0] v);
        return {v[3:0], v, ~v, v};
    endfunction

    always #12.5 clk = ~clk;
    initial begin
        #7;
        forever #100 wclk = ~wclk;
    end
    always @(negedge wclk) begin
        tx_word <= pat(n);
        n <= n + 8'h01;
    end

    seven_to_one_lane_serdes #(.SETTLE_CYCLES(SETTLE), .FIFO_DEPTH(16)) seven_to_one_lane_serdes_inst (
        .clk(clk), .srst(srst), .tx_word_clock_in(wclk), .tx_parallel_in(tx_word),
        .tx_power_down_n(tx_pd_n), .tx_serial_lane_p(lp), .tx_serial_lane_n(ln),
        .tx_serial_lane_oe(lane_oe), .tx_forwarded_clock_p(fp), .tx_forwarded_clock_n(fn),
        .tx_forwarded_clock_oe(f_oe), .tx_overrun(ovr), .rx_serial_lane_p(rlp),
        .rx_serial_lane_n(rln), .rx_forwarded_clock_p(rfp), .rx_forwarded_clock_n(rfn),
        .rx_power_down_n(rx_pd_n), .rx_parallel_out(rx_word), .rx_word_clock_out(rx_clk),
        .rx_locked(locked));
    link_cable link_cable_inst (.clk(clk), .lane_p(lp), .lane_n(ln), .lane_oe(lane_oe),
        .fclk_p(fp), .fclk_n(fn), .fclk_oe(f_oe), .rx_lane_p(rlp), .rx_lane_n(rln),
        .rx_fclk_p(rfp), .rx_fclk_n(rfn));

    task automatic check(input logic [27:0] g, input logic [27:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Word receiver: samples on output clock rise, one word per period
    always @(negedge clk) begin
        if (chk_on && locked && rx_clk && !rx_prev && rx_word !== 28'h000_0000) begin
            check(rx_word, pat(rx_word[7:0]));
            if (seen) check({20'h0_0000, rx_word[7:0]}, {20'h0_0000, last_v + 8'h01});
            seen = 1'b1;
            last_v = rx_word[7:0];
            got++;
        end
        rx_prev = rx_clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic wait_lock(input logic want);
        for (int i = 0; i < 3000 && locked !== want; i++) @(negedge clk);
        check({27'h0, locked}, {27'h0, want});
    endtask

    task automatic t_stream();
        int t[2];
        int k;
        logic fprev;
        wait_lock(1'b1);
        seen = 1'b0;
        got = 0;
        chk_on = 1'b1;
        for (int i = 0; i < 400 && got < 12; i++) @(negedge clk);
        check(28'(got >= 12), 28'h000_0001);
        check({27'h0, ovr}, 28'h000_0000);
        k = 0;
        fprev = fp;
        for (int i = 0; i < 40 && k < 2; i++) begin
            @(negedge clk);
            if (fp && !fprev) t[k++] = i;
            fprev = fp;
        end
        check(28'(t[1] - t[0]), 28'h000_0008);
        $display("stream test done");
    endtask

    task automatic t_rx_hold();
        logic [27:0] held;
        chk_on = 1'b0;
        @(posedge clk) rx_pd_n <= 1'b0;
        repeat (4) @(negedge clk);
        held = rx_word;
        repeat (40) @(negedge clk);
        check(rx_word, held);
        @(posedge clk) rx_pd_n <= 1'b1;
        $display("receiver power-down test done");
    endtask

    task automatic t_tx_down();
        logic [27:0] held;
        logic        hc;
        logic        bad;
        chk_on = 1'b0;
        repeat (3) @(posedge clk);
        tx_pd_n <= 1'b0;
        repeat (6) @(negedge clk);
        check({27'h0, lane_oe | f_oe}, 28'h000_0000);
        wait_lock(1'b0);
        held = rx_word;
        hc = rx_clk;
        repeat (40) @(negedge clk);
        check(rx_word, held);
        check({27'h0, rx_clk}, {27'h0, hc});
        @(posedge clk) tx_pd_n <= 1'b1;
        bad = 1'b0;
        repeat (SETTLE) begin
            @(negedge clk);
            bad = bad | (fp !== 1'b0) | (lp !== 4'h0);
        end
        check({27'h0, bad}, 28'h000_0000);
        $display("transmitter power-down test done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        check({25'h0, lane_oe, f_oe, locked}, 28'h000_0000);
        srst <= 1'b0;
        tx_pd_n <= 1'b1;
        rx_pd_n <= 1'b1;
        t_stream();
        t_rx_hold();
        t_stream();
        t_tx_down();
        t_stream();
        tally_and_finish();
    end
endmodule

`default_nettype wire
